// >>> verilog/seq_cursor_defs.vh
// constants for the cursor, palette and display fifo threshold registers
// Function
// - with border protect set, the border colour comes from extended palette entry 258.
// - with border protect clear, the border uses the entry named by the border palette index register.
// - palette entry 258 is reachable by the host only while extended colour access is set.
// - cursor size 0 gives a 32 by 32 cursor and 1 gives a 64 by 64 cursor.
// - with extended access set, low index x0h is cursor background, xFh cursor foreground, X2h border.
// - with extended access clear, palette addressing is plain standard palette with no extra entries.
// - cursor enable 1 shows the hardware cursor and 0 suppresses it entirely.
// - in 32 by 32 size the 6-bit select picks one of 64 patterns in the top 16 Kbytes of memory.
// - in 64 by 64 size only select bits 5:2 pick one of 16 patterns and bits 1:0 are ignored.
// - the 4-bit fifo threshold sets the level at which display refill cycles start, holding off others.
// - inside the video window the secondary threshold replaces the primary one.
`ifndef SEQ_CURSOR_DEFS_VH
`define SEQ_CURSOR_DEFS_VH
`define IDX_CURSOR_ATTR 8'h12
`define IDX_CURSOR_PAT 8'h13
`define IDX_SCRATCH_TWO 8'h14
`define IDX_SCRATCH_THREE 8'h15
`define IDX_FIFO_THRESH 8'h16
`define ATTR_WMASK 8'h87
`define PAT_WMASK 8'h3F
`define THRESH_WMASK 8'h0F
`define REG_RESET 8'h00
`define BIT_CURSOR_EN 0
`define BIT_EXT_ACCESS 1
`define BIT_CURSOR_SIZE 2
`define BIT_BORDER_PROT 7
`define LUT_NORMAL_TOP 2'h0
`define LUT_EXT_CURSOR_BG 2'h1
`define LUT_EXT_CURSOR_FG 2'h2
`define LUT_EXT_BORDER 2'h3
`define LOW_NIB_BG 4'h0
`define LOW_NIB_FG 4'hF
`define LOW_NIB_BORDER 4'h2
`define BORDER_EXT_ENTRY 9'h102
`define EXT_ENTRY_BG 9'h100
`define EXT_ENTRY_FG 9'h101
`define PAT_TOP_LSB 14
`define PAT_LARGE_FIELD 13:10
`define PAT_SMALL_FIELD 13:8
`define SEL_LARGE_FIELD 5:2
`define SEL_SMALL_FIELD 5:0
`define PAT_BYTES_32 10'h100
`define PAT_BYTES_64 10'h400
`endif

// >>> verilog/palette_index_map.v
// maps host palette index to a palette entry, adding extended entries
`timescale 1ns/10ps
`include "seq_cursor_defs.vh"
module palette_index_map
(
  // control
  input wire ext_access,
  // host index
  input wire [7:0] host_index,
  // mapped entry, 0..255 normal, 256..258 extended
  output reg [8:0] lut_entry
);
  always @*
  begin
    lut_entry = {1'b0, host_index};
    // entry 258 only with access set
    if (ext_access)
    begin
      case (host_index[3:0])
        `LOW_NIB_BG: lut_entry = `EXT_ENTRY_BG;
        `LOW_NIB_FG: lut_entry = `EXT_ENTRY_FG;
        `LOW_NIB_BORDER: lut_entry = `BORDER_EXT_ENTRY;
        default: lut_entry = {1'b0, host_index};
      endcase
    end
  end
endmodule

// >>> verilog/fifo_refill_ctrl.v
// display fifo refill request against threshold
`timescale 1ns/10ps
module fifo_refill_ctrl
#(
  parameter LEVEL_W = 4
)
(
  input wire core_clk,
  input wire rst_n,
  input wire [LEVEL_W-1:0] primary_thresh,
  input wire [LEVEL_W-1:0] secondary_thresh,
  input wire in_video_window,
  input wire [LEVEL_W-1:0] fifo_level,
  output reg refill_req
);
  wire [LEVEL_W-1:0] active_thresh;
  assign active_thresh = in_video_window ? secondary_thresh : primary_thresh;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      refill_req <= 1'b0;
    else
      refill_req <= (fifo_level <= active_thresh);
  end
endmodule

// >>> verilog/cursor_attr_fifo_threshold_regs.v
// sequencer cursor, palette extension and fifo threshold register bank
`timescale 1ns/10ps
`include "seq_cursor_defs.vh"
module cursor_attr_fifo_threshold_regs
#(
  parameter MEM_ADDR_W = 22,
  parameter LEVEL_W = 4
)
(
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // sequencer index/data port, index already latched by the port logic
  input wire [7:0] seq_index,
  input wire seq_wr,
  input wire [7:0] seq_wdata,
  output reg [7:0] seq_rdata,
  // host palette index
  input wire [7:0] pal_host_index,
  output reg [8:0] pal_entry,
  // border source
  input wire [7:0] border_palette_index_reg,
  output reg [8:0] border_entry,
  // cursor control
  output reg cursor_show,
  output reg cursor_large,
  output reg [MEM_ADDR_W-1:0] cursor_pat_addr,
  // display fifo
  input wire [LEVEL_W-1:0] secondary_fifo_threshold_reg,
  input wire in_video_window,
  input wire [LEVEL_W-1:0] fifo_level,
  output wire refill_req,
  output reg hold_off_cpu
);
////////////////////////////////////////////////////////////////////////////////
  reg rst_meta;
  reg rst_n;
  reg [7:0] cursor_attribute_reg;
  reg [7:0] cursor_pattern_reg;
  reg [7:0] scratch_pad_two_reg;
  reg [7:0] scratch_pad_three_reg;
  reg [7:0] fifo_threshold_reg;
  reg [7:0] next_rdata;
  reg [MEM_ADDR_W-1:0] next_pat_addr;
  wire [8:0] mapped_entry;
  wire refill_int;
  // two-stage reset release
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // register writes; scratch and threshold are firmware-only by convention,
  // hardware cannot tell who writes so it does not block them
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cursor_attribute_reg <= `REG_RESET;
      cursor_pattern_reg <= `REG_RESET;
      scratch_pad_two_reg <= `REG_RESET;
      scratch_pad_three_reg <= `REG_RESET;
      fifo_threshold_reg <= `REG_RESET;
    end
    else if (seq_wr)
    begin
      case (seq_index)
        `IDX_CURSOR_ATTR: cursor_attribute_reg <= seq_wdata & `ATTR_WMASK;
        `IDX_CURSOR_PAT: cursor_pattern_reg <= seq_wdata & `PAT_WMASK;
        `IDX_SCRATCH_TWO: scratch_pad_two_reg <= seq_wdata;
        `IDX_SCRATCH_THREE: scratch_pad_three_reg <= seq_wdata;
        `IDX_FIFO_THRESH: fifo_threshold_reg <= seq_wdata & `THRESH_WMASK;
        default: cursor_attribute_reg <= cursor_attribute_reg;
      endcase
    end
  end
////////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    case (seq_index)
      `IDX_CURSOR_ATTR: next_rdata = cursor_attribute_reg;
      `IDX_CURSOR_PAT: next_rdata = cursor_pattern_reg;
      `IDX_SCRATCH_TWO: next_rdata = scratch_pad_two_reg;
      `IDX_SCRATCH_THREE: next_rdata = scratch_pad_three_reg;
      `IDX_FIFO_THRESH: next_rdata = fifo_threshold_reg;
      default: next_rdata = `REG_RESET;
    endcase
  end
  // pattern base: top 16 Kbytes, 256 bytes per small pattern, 1 Kbyte per large
  always @*
  begin
    next_pat_addr = {MEM_ADDR_W{1'b1}} << `PAT_TOP_LSB;
    // large cursor ignores low select bits
    if (cursor_attribute_reg[`BIT_CURSOR_SIZE])
      next_pat_addr[`PAT_LARGE_FIELD] = cursor_pattern_reg[`SEL_LARGE_FIELD];
    // small cursor uses all six bits
    else
      next_pat_addr[`PAT_SMALL_FIELD] = cursor_pattern_reg[`SEL_SMALL_FIELD];
  end
  palette_index_map u_map
  (
    .ext_access(cursor_attribute_reg[`BIT_EXT_ACCESS]),
    .host_index(pal_host_index),
    .lut_entry(mapped_entry)
  );
  fifo_refill_ctrl #(.LEVEL_W(LEVEL_W)) u_refill
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .primary_thresh(fifo_threshold_reg[LEVEL_W-1:0]),
    .secondary_thresh(secondary_fifo_threshold_reg),
    .in_video_window(in_video_window),
    .fifo_level(fifo_level),
    .refill_req(refill_int)
  );
  assign refill_req = refill_int;
////////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_rdata <= `REG_RESET;
      pal_entry <= 9'h000;
      border_entry <= 9'h000;
      cursor_show <= 1'b0;
      cursor_large <= 1'b0;
      cursor_pat_addr <= {MEM_ADDR_W{1'b0}};
      hold_off_cpu <= 1'b0;
    end
    else
    begin
      seq_rdata <= next_rdata;
      pal_entry <= mapped_entry;
      if (cursor_attribute_reg[`BIT_BORDER_PROT])
        border_entry <= `BORDER_EXT_ENTRY;
      else
        border_entry <= {1'b0, border_palette_index_reg};
      cursor_show <= cursor_attribute_reg[`BIT_CURSOR_EN];
      cursor_large <= cursor_attribute_reg[`BIT_CURSOR_SIZE];
      cursor_pat_addr <= next_pat_addr;
      // hold off other cycles while refilling
      hold_off_cpu <= refill_int;
    end
  end
endmodule

// >>> sim/cursor_regs_asserts.sv
// checker for the cursor attribute and fifo threshold register bank
`timescale 1ns/10ps
module cursor_regs_checker
#(
  parameter MEM_ADDR_W = 22,
  parameter LEVEL_W = 4
)
(
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // register port
  input wire [7:0] seq_index,
  input wire seq_wr,
  input wire [7:0] seq_wdata,
  input wire [7:0] seq_rdata,
  // palette and border
  input wire [7:0] pal_host_index,
  input wire [8:0] pal_entry,
  input wire [7:0] border_palette_index_reg,
  input wire [8:0] border_entry,
  // cursor
  input wire cursor_show,
  input wire cursor_large,
  input wire [MEM_ADDR_W-1:0] cursor_pat_addr,
  // display fifo
  input wire [LEVEL_W-1:0] secondary_fifo_threshold_reg,
  input wire in_video_window,
  input wire [LEVEL_W-1:0] fifo_level,
  input wire refill_req,
  input wire hold_off_cpu
);
  // outputs stay cleared two edges after release, so wait them out
  reg [1:0] up;
  always @(posedge core_clk or negedge resetn)
    if (!resetn) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn || up != 2'h3);
  ////////////////////////////////////////////////////////////////
  a_show_size: assert property (seq_wr && seq_index == 8'h12 |-> ##2
    {cursor_large, cursor_show} == {$past(seq_wdata[2], 2), $past(seq_wdata[0], 2)}) else $error("cursor bits wrong");
  a_border_src: assert property (seq_wr && seq_index == 8'h12 |-> ##2 border_entry ==
    ($past(seq_wdata[7], 2) ? 9'h102 : {1'b0, $past(border_palette_index_reg)})) else $error("border entry wrong");
  a_pal_ext: assert property (seq_wr && seq_index == 8'h12 && seq_wdata[1] ##1 pal_host_index[3:0] == 4'h2
    |=> pal_entry == 9'h102) else $error("extended entry not mapped");
  a_pal_std: assert property (seq_wr && seq_index == 8'h12 && !seq_wdata[1] |-> ##2
    pal_entry == {1'b0, $past(pal_host_index)}) else $error("standard palette mapping wrong");
  a_pat_small: assert property (seq_wr && seq_index == 8'h13 |-> ##2 (&cursor_pat_addr[MEM_ADDR_W-1:14]) &&
    (cursor_large || cursor_pat_addr[13:8] == $past(seq_wdata[5:0], 2))) else $error("pattern address wrong");
  a_pat_large: assert property (cursor_large |-> cursor_pat_addr[9:0] == 10'h000) else $error("large pattern low bits set");
  a_thresh_read: assert property (seq_wr && seq_index == 8'h16 ##1 !seq_wr && seq_index == 8'h16
    |=> seq_rdata == {4'h0, $past(seq_wdata[3:0], 2)}) else $error("threshold readback wrong");
  a_refill_video: assert property ($past(in_video_window) |->
    refill_req == ($past(fifo_level) <= $past(secondary_fifo_threshold_reg))) else $error("video refill wrong");
  a_hold_off: assert property (hold_off_cpu == $past(refill_req)) else $error("hold off not following refill");
  cover property (seq_wr && seq_index == 8'h12 && seq_wdata[1]);
  cover property (in_video_window && refill_req);
  cover property (cursor_large && cursor_show);
endmodule
bind cursor_attr_fifo_threshold_regs cursor_regs_checker #(.MEM_ADDR_W(MEM_ADDR_W), .LEVEL_W(LEVEL_W)) chk_u
  (.core_clk, .resetn, .seq_index, .seq_wr, .seq_wdata, .seq_rdata, .pal_host_index, .pal_entry,
  .border_palette_index_reg, .border_entry, .cursor_show, .cursor_large, .cursor_pat_addr,
  .secondary_fifo_threshold_reg, .in_video_window, .fifo_level, .refill_req, .hold_off_cpu);

// >>> sim/cursor_attr_fifo_threshold_regs_tb.sv
// self-checking bench for the cursor attribute and fifo threshold register bank
`timescale 1ns/10ps
module cursor_attr_fifo_threshold_regs_tb;
  reg core_clk = 0, resetn = 0, seq_wr = 0, in_video_window = 0;
  reg [7:0] seq_index = 0, seq_wdata = 0, pal_host_index = 0, border_palette_index_reg = 0;
  reg [3:0] secondary_fifo_threshold_reg = 0, fifo_level = 0;
  wire [7:0] seq_rdata;
  wire [8:0] pal_entry, border_entry;
  wire [21:0] cursor_pat_addr;
  wire cursor_show, cursor_large, refill_req, hold_off_cpu;
  integer n_fail = 0, n_compared = 0, cyc = 0, i;
  cursor_attr_fifo_threshold_regs dut_u (.core_clk, .resetn, .seq_index, .seq_wr, .seq_wdata, .seq_rdata,
    .pal_host_index, .pal_entry, .border_palette_index_reg, .border_entry, .cursor_show, .cursor_large,
    .cursor_pat_addr, .secondary_fifo_threshold_reg, .in_video_window, .fifo_level, .refill_req, .hold_off_cpu);
  always #10 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  task final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the whole run is under a hundred cycles
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  task chk(input [21:0] seen, input [21:0] exp, input string nm);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input [7:0] idx, input [7:0] d);
    @(posedge core_clk);
    seq_index <= idx;
    seq_wr <= 1'b1;
    seq_wdata <= d;
    @(posedge core_clk);
    seq_wr <= 1'b0;
  endtask
  task rd(input [7:0] idx, input [7:0] exp);
    @(posedge core_clk);
    seq_index <= idx;
    w(2);
    chk(seq_rdata, exp, "seq_rdata");
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    for (i = 8'h12; i <= 8'h16; i = i + 1) rd(i[7:0], 8'h00);
    $display("reset values done");
  endtask
  task t_regs;
    wr(8'h12, 8'hFF); rd(8'h12, 8'h87);
    wr(8'h13, 8'hFF); rd(8'h13, 8'h3F);
    wr(8'h16, 8'hFF); rd(8'h16, 8'h0F);
    wr(8'h14, 8'hA5); rd(8'h14, 8'hA5);
    wr(8'h15, 8'h5A); rd(8'h15, 8'h5A);
    wr(8'h17, 8'hFF); rd(8'h17, 8'h00);
    $display("register access done");
  endtask
  task t_cursor;
    @(posedge core_clk);
    pal_host_index <= 8'h32;
    border_palette_index_reg <= 8'h07;
    wr(8'h12, 8'h87);
    wr(8'h13, 8'h3F);
    w(2);
    chk(cursor_show, 1, "cursor_show");
    chk(cursor_large, 1, "cursor_large");
    chk(border_entry, 9'h102, "border_entry");
    chk(pal_entry, 9'h102, "pal_entry");
    chk(cursor_pat_addr, 22'h3FFC00, "cursor_pat_addr");
    wr(8'h12, 8'h00);
    w(2);
    chk(cursor_show, 0, "cursor_show");
    chk(cursor_large, 0, "cursor_large");
    chk(border_entry, 9'h007, "border_entry");
    chk(pal_entry, 9'h032, "pal_entry");
    chk(cursor_pat_addr, 22'h3FFF00, "cursor_pat_addr");
    $display("cursor and palette done");
  endtask
  task t_fifo;
    wr(8'h16, 8'h04);
    fifo_level <= 4'h4;
    w(3);
    chk(refill_req, 1, "refill_req");
    @(posedge core_clk);
    fifo_level <= 4'h5;
    w(3);
    chk(refill_req, 0, "refill_req");
    @(posedge core_clk);
    in_video_window <= 1'b1;
    secondary_fifo_threshold_reg <= 4'h6;
    w(3);
    chk(refill_req, 1, "refill_req");
    chk(hold_off_cpu, 1, "hold_off_cpu");
    $display("fifo threshold done");
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_regs;
    t_cursor;
    t_fifo;
    final_report;
  end
endmodule
